/* hw/ntl_pkg.sv */
// package: offsets, fields, reset values and timing for the trap and low-power controller
package ntl_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] NTL_CTRL_OFF = 8'h00;
  localparam logic [7:0] NTL_STAT_OFF = 8'h04;
  localparam logic [7:0] NTL_CMD_OFF = 8'h08;
  localparam logic [7:0] NTL_CCR_OFF = 8'h0c;
  localparam logic [7:0] NTL_SRC_OFF = 8'h10;
  localparam logic [7:0] NTL_FLAG_OFF = 8'h14;
  localparam logic [7:0] NTL_SP_OFF = 8'h18;
  // condition code bit positions
  localparam int NTL_CCR_S = 7;
  localparam int NTL_CCR_X = 6;
  localparam int NTL_CCR_I = 4;
  localparam logic [7:0] NTL_CCR_RST = 8'hd0;
  // control bit positions
  localparam int NTL_CTRL_DLY = 0;
  localparam int NTL_CTRL_NOWD = 1;
  localparam logic [1:0] NTL_CTRL_RST = 2'h3;
  // command codes written to the command register
  localparam logic [2:0] NTL_CMD_NONE = 3'h0;
  localparam logic [2:0] NTL_CMD_TAP = 3'h1;
  localparam logic [2:0] NTL_CMD_SWI = 3'h2;
  localparam logic [2:0] NTL_CMD_WAIT = 3'h3;
  localparam logic [2:0] NTL_CMD_STOP = 3'h4;
  localparam logic [2:0] NTL_CMD_RTI = 3'h5;
  localparam logic [2:0] NTL_CMD_ILL = 3'h6;
  localparam logic [2:0] NTL_CMD_END = 3'h7;
  // number of peripheral flag sources
  localparam int NTL_NSRC = 8;
  localparam logic [15:0] NTL_SP_RST = 16'h00ff;
  localparam logic [15:0] NTL_STACK_BYTES = 16'h0008;
  // oscillator restart delay
  localparam int NTL_CLK_MHZ = 40;
  localparam int NTL_DLY_US = 100;
  localparam int NTL_DLY_CYC = NTL_DLY_US * NTL_CLK_MHZ;
  // vector selector codes
  typedef enum logic [2:0] {
    NTL_VEC_NONE, NTL_VEC_ILL, NTL_VEC_SWI, NTL_VEC_NONMASKABLE_REQUEST_PIN, NTL_VEC_IRQ, NTL_VEC_PERIPH
  } ntl_vec_t;
endpackage : ntl_pkg

/* hw/ntl_ctrl.sv */
// trap, interrupt priority and standby controller with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module ntl_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic por_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // request pins, active low apart from the active-high edge pending line
  input wire logic irq_req_n_i,
  input wire logic nonmaskable_request_pin_n_i,
  input wire logic irq_edge_pend_i,
  // peripheral source flags
  input wire logic [ntl_pkg::NTL_NSRC-1:0] periph_event_i,
  // cpu steering
  output logic [15:0] stack_addr_o,
  output logic stack_rd_o,
  output logic vec_fetch_o,
  output ntl_pkg::ntl_vec_t vec_sel_o,
  output logic osc_run_o,
  output logic clk_run_o,
  output logic timer_run_o,
  output logic cpu_halt_o
);
  import ntl_pkg::*;

  typedef enum logic [1:0] {NTL_RUN, NTL_WAIT, NTL_STOP, NTL_DELAY} ntl_state_t;

  // pin synchronisers: stage one only feeds stage two
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [NTL_NSRC-1:0] ev_s1_r;
  logic [NTL_NSRC-1:0] ev_s2_r;
  logic [NTL_NSRC-1:0] ev_d_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      ev_s1_r <= '0;
      ev_s2_r <= '0;
      ev_d_r <= '0;
    end else begin
      pin_s1_r <= {irq_req_n_i, nonmaskable_request_pin_n_i, ~irq_edge_pend_i};
      pin_s2_r <= pin_s1_r;
      ev_s1_r <= periph_event_i;
      ev_s2_r <= ev_s1_r;
      ev_d_r <= ev_s2_r;
    end
  end
  wire irq_low = ~pin_s2_r[2];
  wire nonmaskable_request_pin_low = ~pin_s2_r[1];
  wire edge_pend = ~pin_s2_r[0];

  // power-up marker: low only in the first cycle after any reset release,
  // so a power-on start loads the oscillator restart count exactly once;
  // a warm reset leaves por_i low and skips the long restart
  logic por_seen_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_seen_r <= 1'b0;
    end else begin
      por_seen_r <= 1'b1;
    end
  end
  wire power_up = por_i & ~por_seen_r;

  // register state
  // ccr_r models the condition code byte: s stop-disable, x nonmaskable
  // mask, i global mask; other bits are plain storage for software
  // sp_r is the stack pointer; the seven-register push is modelled only
  // as a step of eight bytes, the bytes themselves live in cpu memory
  // saved_ccr_r stands in for the stacked condition code byte, so only
  // one nesting level is tracked; a nested entry overwrites it
  // pc_r keeps the first-byte address reported with a trap
  // limitation: nesting deeper than one level needs a real stack
  logic [7:0] ccr_r;
  logic [7:0] ccr_nxt;
  logic [1:0] ctrl_r;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [15:0] pc_r;
  logic [NTL_NSRC-1:0] flag_r;
  logic [NTL_NSRC-1:0] en_r;
  logic [15:0] dly_cnt_r;
  logic [15:0] dly_cnt_nxt;
  logic [7:0] saved_ccr_r;
  logic resume_r;
  logic ill_pend_r;
  logic swi_pend_r;
  logic [31:0] hrdata_nxt;
  ntl_state_t state_r;
  ntl_state_t state_nxt;
  ntl_vec_t vec_r;
  ntl_vec_t vec_nxt;

  // ahb address phase capture
  logic wr_ph_r;
  logic [7:0] addr_r;
  wire take = hsel_i & hready_i & htrans_i[1];
  wire wr_go = wr_ph_r;
  wire hit_ctrl = addr_r == NTL_CTRL_OFF;
  wire hit_cmd = addr_r == NTL_CMD_OFF;
  wire hit_ccr = addr_r == NTL_CCR_OFF;
  wire hit_src = addr_r == NTL_SRC_OFF;
  wire hit_flag = addr_r == NTL_FLAG_OFF;
  wire hit_sp = addr_r == NTL_SP_OFF;
  wire [2:0] cmd = (wr_go && hit_cmd) ? hwdata_i[2:0] : NTL_CMD_NONE;
  wire [15:0] cmd_pc = hwdata_i[31:16];

  // a flag is set on the rising edge of its synchronised event line;
  // the edge detector resets to zero like the idle line, so reset
  // release never fakes an event
  // when event and clear meet in one cycle the event wins, so no
  // event is ever lost to a late clear
  // each source holds its request while flag and enable are set
  wire [NTL_NSRC-1:0] flag_clr = (wr_go && hit_flag) ? hwdata_i[NTL_NSRC-1:0] : '0;
  genvar g;
  generate
    for (g = 0; g < NTL_NSRC; g++) begin : g_flag
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flag_r[g] <= 1'b0;
        end else if (ev_s2_r[g] && !ev_d_r[g]) begin
          flag_r[g] <= 1'b1;
        end else if (flag_clr[g]) begin
          flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  wire periph_req = |(flag_r & en_r);

  // the two traps come from the decoder and are never masked; the
  // nonmaskable pin is gated by x only, the pin and peripheral
  // requests by i only
  // requests are only looked at when an instruction ends (end or wait
  // command) or while already waiting, never in mid-instruction
  // resume_r blocks service for the one cycle after a stop left with
  // x set, so the waking pin edge does not leave a request behind
  // hazard: vec_nxt is combinational and may glitch; it only feeds register inputs
  // priority: trap, software trap, nonmaskable, then i-gated sources
  wire nonmaskable_request_pin_ok = nonmaskable_request_pin_low & ~ccr_r[NTL_CCR_X];
  wire irq_ok = (irq_low | periph_req) & ~ccr_r[NTL_CCR_I];
  wire at_end = (cmd == NTL_CMD_END) | (cmd == NTL_CMD_WAIT);
  always_comb begin
    vec_nxt = NTL_VEC_NONE;
    if (ill_pend_r) begin
      vec_nxt = NTL_VEC_ILL;
    end else if (swi_pend_r) begin
      vec_nxt = NTL_VEC_SWI;
    end else if (nonmaskable_request_pin_ok) begin
      vec_nxt = NTL_VEC_NONMASKABLE_REQUEST_PIN;
    end else if (irq_ok && irq_low) begin
      vec_nxt = NTL_VEC_IRQ;
    end else if (irq_ok) begin
      vec_nxt = NTL_VEC_PERIPH;
    end
  end
  wire svc_now = (vec_nxt != NTL_VEC_NONE) &&
                 ((state_r == NTL_RUN && at_end) || state_r == NTL_WAIT) && !resume_r;

  // stop is left on the nonmaskable pin whatever x holds, on a pending
  // edge request, or on the maskable pin only while i is clear
  // the restart delay runs only when the delay enable is set; a clear
  // bit trades oscillator settling for a faster return to work
  // a wait command that meets a serviceable request is serviced at once
  // and does not park the controller in wait, which would otherwise
  // stay there with i set and nothing able to wake it
  // mask updates of a service entry are applied after the stacked copy
  // stop wake and mask update
  wire stop_wake = nonmaskable_request_pin_low | edge_pend | (irq_low & ~ccr_r[NTL_CCR_I]);
  always_comb begin
    ccr_nxt = ccr_r;
    sp_nxt = sp_r;
    state_nxt = state_r;
    dly_cnt_nxt = dly_cnt_r;
    if (wr_go && hit_ccr) begin
      ccr_nxt = {hwdata_i[7], ccr_r[NTL_CCR_X] & hwdata_i[6], hwdata_i[5:0]};
    end
    if (cmd == NTL_CMD_TAP) begin
      ccr_nxt[NTL_CCR_X] = ccr_r[NTL_CCR_X] & hwdata_i[8 + NTL_CCR_X];
    end
    if (cmd == NTL_CMD_RTI) begin
      ccr_nxt = saved_ccr_r;
      sp_nxt = sp_r + NTL_STACK_BYTES;
    end
    case (state_r)
      NTL_RUN: begin
        if (cmd == NTL_CMD_WAIT) begin
          sp_nxt = sp_r - NTL_STACK_BYTES;
          state_nxt = svc_now ? NTL_RUN : NTL_WAIT;
        end else if (cmd == NTL_CMD_STOP && !ccr_r[NTL_CCR_S]) begin
          state_nxt = NTL_STOP;
        end
      end
      NTL_WAIT: begin
        if (vec_nxt != NTL_VEC_NONE) begin
          state_nxt = NTL_RUN;
        end
      end
      NTL_STOP: begin
        if (stop_wake) begin
          state_nxt = ctrl_r[NTL_CTRL_DLY] ? NTL_DELAY : NTL_RUN;
          dly_cnt_nxt = 16'(NTL_DLY_CYC - 1);
        end
      end
      NTL_DELAY: begin
        if (power_up) begin
          dly_cnt_nxt = 16'(NTL_DLY_CYC - 1);
        end else if (dly_cnt_r == 16'h0000) begin
          state_nxt = NTL_RUN;
        end else begin
          dly_cnt_nxt = dly_cnt_r - 16'h0001;
        end
      end
      default: state_nxt = NTL_RUN;
    endcase
    if (svc_now) begin
      if (state_r == NTL_RUN) begin
        sp_nxt = sp_r - NTL_STACK_BYTES;
      end
      ccr_nxt[NTL_CCR_I] = 1'b1;
      if (vec_nxt == NTL_VEC_NONMASKABLE_REQUEST_PIN) begin
        ccr_nxt[NTL_CCR_X] = 1'b1;
      end
    end
  end

  // all cpu-side registers update together on every edge; the ctrl, source
  // enable and sp write paths sit last so a software write wins there; a ccr
  // write yields to a same-cycle service mask update, and x is one-way
  // the stacked condition code copy is taken from ccr_r, which still
  // holds the value from before this cycle's mask update
  // reset parks the machine in the restart-delay state with a zero
  // count; a power-on start then loads the full count on its first edge
  // a reset out of stop reinitialises every register here
  // cpu side state; stacked ccr is captured before masks change
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ccr_r <= NTL_CCR_RST;
      ctrl_r <= NTL_CTRL_RST;
      sp_r <= NTL_SP_RST;
      pc_r <= 16'h0000;
      en_r <= '0;
      saved_ccr_r <= NTL_CCR_RST;
      state_r <= NTL_DELAY;
      dly_cnt_r <= 16'h0000;
      vec_r <= NTL_VEC_NONE;
      resume_r <= 1'b0;
      ill_pend_r <= 1'b0;
      swi_pend_r <= 1'b0;
    end else begin
      ccr_r <= ccr_nxt;
      sp_r <= sp_nxt;
      state_r <= state_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      vec_r <= svc_now ? vec_nxt : NTL_VEC_NONE;
      if ((svc_now && state_r == NTL_RUN) || cmd == NTL_CMD_WAIT) begin
        saved_ccr_r <= ccr_r;
      end
      if (cmd == NTL_CMD_ILL || cmd == NTL_CMD_SWI) begin
        pc_r <= cmd_pc;
      end
      ill_pend_r <= (ill_pend_r & ~(svc_now && vec_nxt == NTL_VEC_ILL)) |
                    (cmd == NTL_CMD_ILL);
      swi_pend_r <= (swi_pend_r & ~(svc_now && vec_nxt == NTL_VEC_SWI)) |
                    (cmd == NTL_CMD_SWI);
      // x set at stop wake by the pin: resume after stop, nothing pending
      resume_r <= (state_r == NTL_STOP) && nonmaskable_request_pin_low && ccr_r[NTL_CCR_X];
      if (wr_go && hit_ctrl) begin
        ctrl_r <= hwdata_i[1:0];
      end
      if (wr_go && hit_src) begin
        en_r <= hwdata_i[NTL_NSRC-1:0];
      end
      if (wr_go && hit_sp) begin
        sp_r <= hwdata_i[15:0];
      end
    end
  end

  // the slave never stretches a transfer: the address phase is taken
  // on the edge where htrans is nonseq, and the data phase follows
  // a write lands on the edge that ends its data phase; a read returns
  // the register values as they stand during the data phase
  // non-word writes are dropped rather than merged, since every
  // register is one whole word
  // unmapped addresses read as zero and still answer okay
  // ahb-lite slave: zero wait states, always okay
  wire hit_stat = addr_r == NTL_STAT_OFF;
  wire rd_hit = hit_ctrl | hit_stat | hit_ccr | hit_src | hit_flag | hit_sp;
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      hrdata_nxt = {30'h0, ctrl_r};
    end else if (hit_stat) begin
      hrdata_nxt = {pc_r, 8'h00, 3'(vec_r), 3'h0, 2'(state_r)};
    end else if (hit_ccr) begin
      hrdata_nxt = {24'h0, ccr_r};
    end else if (hit_src) begin
      hrdata_nxt = {24'h0, en_r};
    end else if (hit_flag) begin
      hrdata_nxt = {24'h0, flag_r};
    end else if (hit_sp) begin
      hrdata_nxt = {16'h0, sp_r};
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ph_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_ph_r <= take & hwrite_i & (hsize_i == 3'h2);
      addr_r <= take ? haddr_i[7:0] : 8'hff;
    end
  end
  assign hrdata_o = rd_hit ? hrdata_nxt : 32'h0000_0000;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // steering levels are decoded from registered state only, so they
  // change one edge after the command or wake that causes them
  // the oscillator runs in wait and in the restart delay; cpu clocks
  // stay held through the delay so the cpu does not run on an unsettled clock; the timer still runs
  // the timer stops in wait only with i set and the watchdog off,
  // otherwise the watchdog could not time out during wait
  // the wait read address is the stacked condition code byte at sp+1
  // cpu steering outputs
  wire in_stop = state_r == NTL_STOP;
  assign osc_run_o = ~in_stop;
  assign clk_run_o = ~in_stop & ~(state_r == NTL_DELAY);
  assign cpu_halt_o = state_r != NTL_RUN;
  assign stack_rd_o = state_r == NTL_WAIT;
  assign stack_addr_o = sp_r + 16'h0001;
  assign timer_run_o = ~(state_r == NTL_WAIT && ccr_r[NTL_CCR_I] &&
                         ctrl_r[NTL_CTRL_NOWD]) & ~in_stop;
  assign vec_fetch_o = vec_r != NTL_VEC_NONE;
  assign vec_sel_o = vec_r;
endmodule : ntl_ctrl
`default_nettype wire

/* test/ntl_src_model.sv */
// model of the external request sources and the peripheral event lines
`timescale 1ns/100ps
`default_nettype none
module ntl_src_model (
  // requests from the bench
  input wire logic [1:0] irq_pull_i,
  input wire logic nmr_pull_i,
  input wire logic pend_i,
  input wire logic [7:0] evt_i,
  // lines into the controller
  output logic irq_req_n_o,
  output logic nmr_n_o,
  output logic edge_pend_o,
  output logic [7:0] periph_event_o
);
  // shared request line: any source pulling drags it low, released it floats high
  assign irq_req_n_o = ~|irq_pull_i;
  // wake lines stay asserted until the bench has seen the wake-up
  assign nmr_n_o = ~nmr_pull_i;
  assign edge_pend_o = pend_i;
  assign periph_event_o = evt_i;
endmodule : ntl_src_model
`default_nettype wire

/* test/ntl_properties.sv */
// checker: port-level timing relations of the trap and standby controller
`timescale 1ns/100ps
`default_nettype none
module ntl_properties (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // request pins
  input wire logic irq_req_n_i,
  input wire logic nonmaskable_request_pin_n_i,
  input wire logic irq_edge_pend_i,
  // outputs watched
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic stack_rd_o,
  input wire logic vec_fetch_o,
  input wire ntl_pkg::ntl_vec_t vec_sel_o,
  input wire logic osc_run_o,
  input wire logic clk_run_o,
  input wire logic timer_run_o,
  input wire logic cpu_halt_o
);
  import ntl_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // stopped with a wake line active, and the restart that must follow
  sequence s_wake;
    !osc_run_o && (!nonmaskable_request_pin_n_i || irq_edge_pend_i);
  endsequence
  sequence s_back;
    ##[1:6] osc_run_o;
  endsequence
  // three quiet cycles cover the two-flop input pipeline
  sequence s_quiet;
    (!osc_run_o && nonmaskable_request_pin_n_i && irq_req_n_i && !irq_edge_pend_i) [*3];
  endsequence
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  a_fetch_pulse: assert property (vec_fetch_o |=> !vec_fetch_o)
    else $error("vector fetch held beyond one cycle");
  a_fetch_vec: assert property (vec_fetch_o |-> vec_sel_o != NTL_VEC_NONE)
    else $error("vector fetch with no source selected");
  a_wait_osc: assert property (stack_rd_o |-> osc_run_o && cpu_halt_o)
    else $error("wait without running oscillator or halted cpu");
  a_wait_addr: assert property (stack_rd_o [*2] |-> $stable(stack_addr_o))
    else $error("wait read address moved");
  a_stop_clocks: assert property (!osc_run_o |-> !clk_run_o && !timer_run_o && cpu_halt_o)
    else $error("a clock runs in stop");
  a_stop_wake: assert property (s_wake |-> s_back)
    else $error("stop not left on a wake line");
  a_stop_hold: assert property (s_quiet |=> !osc_run_o)
    else $error("stop left with no wake line");
endmodule : ntl_properties
bind ntl_ctrl ntl_properties i_prop (.ref_clk_i, .rst_n_i, .irq_req_n_i,
  .nonmaskable_request_pin_n_i, .irq_edge_pend_i, .hreadyout_o, .hresp_o, .stack_addr_o,
  .stack_rd_o, .vec_fetch_o, .vec_sel_o, .osc_run_o, .clk_run_o, .timer_run_o, .cpu_halt_o);
`default_nettype wire

/* test/test_nonmaskable_trap_and_low_power_ctrl.sv */
// self-checking bench for the trap and standby controller
`timescale 1ns/100ps
`default_nettype none
module test_nonmaskable_trap_and_low_power_ctrl;
  import ntl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic por = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, irq_n, nmr_n, epend, fetch, osc, clkr, tmr, halt, srd;
  logic [1:0] irq_pull = 2'h0;
  logic nmr_pull = 1'b0;
  logic pend = 1'b0;
  logic [7:0] evt = 8'h0;
  logic [7:0] pev;
  logic [15:0] saddr;
  ntl_vec_t vsel, last_vec;
  int error_cnt = 0, n_compared = 0, cyc = 0, n_fetch = 0, t0, nf;
  always #12.5 ref_clk_i = ~ref_clk_i;
  ntl_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .por_i(por), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .irq_req_n_i(irq_n), .nonmaskable_request_pin_n_i(nmr_n), .irq_edge_pend_i(epend),
    .periph_event_i(pev), .stack_addr_o(saddr), .stack_rd_o(srd), .vec_fetch_o(fetch),
    .vec_sel_o(vsel), .osc_run_o(osc), .clk_run_o(clkr), .timer_run_o(tmr), .cpu_halt_o(halt));
  ntl_src_model i_src (.irq_pull_i(irq_pull), .nmr_pull_i(nmr_pull), .pend_i(pend),
    .evt_i(evt), .irq_req_n_o(irq_n), .nmr_n_o(nmr_n), .edge_pend_o(epend),
    .periph_event_o(pev));
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // count vector fetches; the cycle ceiling cuts a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (fetch === 1'b1) begin
      n_fetch++;
      last_vec = vsel;
    end
    if (cyc > 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single ahb transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic cmd(input logic [2:0] c);
    wr(NTL_CMD_OFF, {29'h0, c});
  endtask : cmd
  task automatic stc(input logic [1:0] s);
    bus(1'b0, NTL_STAT_OFF, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, s});
  endtask : stc
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick
  // poll until running again; the bound keeps a stuck stop from hanging here
  task automatic run_wait(output int dt);
    t0 = cyc;
    do bus(1'b0, NTL_STAT_OFF, 32'h0); while (rd[1:0] !== 2'h0 && cyc - t0 < 9000);
    dt = cyc - t0;
  endtask : run_wait
  task automatic fetch_chk(input ntl_vec_t v);
    t0 = n_fetch;
    for (int i = 0; i < 20 && n_fetch == t0; i++) @(posedge ref_clk_i);
    chk(n_fetch - t0, 32'h1);
    chk({29'h0, last_vec}, {29'h0, v});
  endtask : fetch_chk
  initial begin
    int dt;
    tick(3);
    rst_n_i <= 1'b1;
    run_wait(dt);
    chk({31'h0, dt > 3990 && dt < 4100}, 32'h1);
    rdc(NTL_CCR_OFF, 32'hd0);
    rdc(NTL_CTRL_OFF, 32'h3);
    rdc(NTL_SP_OFF, 32'hff);
    // warm reset while clocks run: no restart delay
    por <= 1'b0;
    rst_n_i <= 1'b0;
    tick(3);
    rst_n_i <= 1'b1;
    run_wait(dt);
    chk({31'h0, dt < 20}, 32'h1);
    $display("test reset done");
    // stop with the nonmaskable line masked: wake without service
    wr(NTL_CCR_OFF, 32'h50);
    cmd(NTL_CMD_STOP);
    stc(2'h2);
    chk({31'h0, osc}, 32'h0);
    irq_pull <= 2'h1;
    tick(8);
    stc(2'h2);
    irq_pull <= 2'h0;
    nf = n_fetch;
    nmr_pull <= 1'b1;
    run_wait(dt);
    chk({31'h0, dt > 3990 && dt < 4100}, 32'h1);
    chk(n_fetch - nf, 32'h0);
    nmr_pull <= 1'b0;
    wr(NTL_CCR_OFF, 32'hd0);
    cmd(NTL_CMD_STOP);
    stc(2'h0);
    // reset out of stop restores the controls
    wr(NTL_CTRL_OFF, 32'h0);
    wr(NTL_CCR_OFF, 32'h50);
    cmd(NTL_CMD_STOP);
    tick(3);
    rst_n_i <= 1'b0;
    tick(3);
    rst_n_i <= 1'b1;
    run_wait(dt);
    rdc(NTL_CCR_OFF, 32'hd0);
    rdc(NTL_CTRL_OFF, 32'h3);
    // delay bypassed, pending edge request wakes
    wr(NTL_CTRL_OFF, 32'h2);
    wr(NTL_CCR_OFF, 32'h50);
    cmd(NTL_CMD_STOP);
    stc(2'h2);
    pend <= 1'b1;
    run_wait(dt);
    chk({31'h0, dt < 20}, 32'h1);
    pend <= 1'b0;
    $display("test stop done");
    // x bit cleared by the transfer, never set again by a write
    cmd(NTL_CMD_TAP);
    rdc(NTL_CCR_OFF, 32'h10);
    wr(NTL_CMD_OFF, 32'h4001);
    wr(NTL_CCR_OFF, 32'h50);
    rdc(NTL_CCR_OFF, 32'h10);
    // both lines low, nothing taken before the instruction ends
    wr(NTL_CCR_OFF, 32'h0);
    irq_pull <= 2'h3;
    nmr_pull <= 1'b1;
    nf = n_fetch;
    tick(5);
    chk(n_fetch - nf, 32'h0);
    cmd(NTL_CMD_END);
    fetch_chk(NTL_VEC_NONMASKABLE_REQUEST_PIN);
    rdc(NTL_CCR_OFF, 32'h50);
    rdc(NTL_SP_OFF, 32'hf7);
    cmd(NTL_CMD_RTI);
    rdc(NTL_CCR_OFF, 32'h0);
    rdc(NTL_SP_OFF, 32'hff);
    nmr_pull <= 1'b0;
    irq_pull <= 2'h2;
    tick(4);
    cmd(NTL_CMD_END);
    fetch_chk(NTL_VEC_IRQ);
    rdc(NTL_CCR_OFF, 32'h10);
    cmd(NTL_CMD_RTI);
    irq_pull <= 2'h0;
    tick(4);
    // illegal trap goes through with the mask set; software trap sets it
    wr(NTL_CCR_OFF, 32'h10);
    wr(NTL_CMD_OFF, 32'h12340006);
    cmd(NTL_CMD_END);
    fetch_chk(NTL_VEC_ILL);
    bus(1'b0, NTL_STAT_OFF, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h1234);
    cmd(NTL_CMD_RTI);
    wr(NTL_CCR_OFF, 32'h0);
    cmd(NTL_CMD_SWI);
    cmd(NTL_CMD_END);
    fetch_chk(NTL_VEC_SWI);
    rdc(NTL_CCR_OFF, 32'h10);
    cmd(NTL_CMD_RTI);
    $display("test priority done");
    // wait with mask set and watchdog off: timer stops, masked flag keeps waiting
    wr(NTL_SRC_OFF, 32'h1);
    wr(NTL_CTRL_OFF, 32'h3);
    wr(NTL_CCR_OFF, 32'h10);
    cmd(NTL_CMD_WAIT);
    stc(2'h1);
    chk({15'h0, srd, saddr}, 32'h100f8);
    chk({30'h0, osc, tmr}, 32'h2);
    evt <= 8'h1;
    tick(1);
    evt <= 8'h0;
    tick(4);
    stc(2'h1);
    rdc(NTL_FLAG_OFF, 32'h1);
    nmr_pull <= 1'b1;
    fetch_chk(NTL_VEC_NONMASKABLE_REQUEST_PIN);
    nmr_pull <= 1'b0;
    tick(4);
    cmd(NTL_CMD_RTI);
    wr(NTL_CCR_OFF, 32'h0);
    cmd(NTL_CMD_WAIT);
    fetch_chk(NTL_VEC_PERIPH);
    cmd(NTL_CMD_RTI);
    wr(NTL_FLAG_OFF, 32'h1);
    rdc(NTL_FLAG_OFF, 32'h0);
    nf = n_fetch;
    cmd(NTL_CMD_END);
    tick(4);
    chk(n_fetch - nf, 32'h0);
    $display("test wait done");
    give_verdict();
  end
endmodule : test_nonmaskable_trap_and_low_power_ctrl
`default_nettype wire
